/* File: verilog/ovw_pkg.sv */
package ovw_pkg;
    // Register map and field widths
    localparam logic [15:0] OVW_THRESH_ADDR  = 16'hFE1A;
    localparam int          OVW_ADDR_W       = 16;
    localparam int          OVW_THRESH_W     = 8;
    localparam int          OVW_CMP_W        = 9;
    localparam int          OVW_ADC_W        = 12;
    localparam logic [7:0]  OVW_THRESH_RST   = 8'h00;
    localparam logic [7:0]  OVW_UNMAPPED_RD  = 8'h00;

    // Threshold scaling: 256 steps across 800 mV, 3.125 mV a step
    localparam int          OVW_STEPS        = 256;
    localparam int          OVW_SPAN_MV      = 800;
    localparam int          OVW_UV_W         = 20;
    localparam logic [19:0] OVW_STEP_UV      = 20'(OVW_SPAN_MV * 1000 / OVW_STEPS);

    // Lowest and highest codes software may program
    localparam logic [7:0]  OVW_THRESH_MIN   = 8'h03;
    localparam logic [7:0]  OVW_THRESH_MAX   = 8'hFA;

    // Debounce time and its length in core clock cycles
    localparam int          OVW_CLK_HZ       = 25_000_000;
    localparam int          OVW_DEBOUNCE_MS  = 100;
    localparam int          OVW_DEBOUNCE_CYC = OVW_DEBOUNCE_MS * (OVW_CLK_HZ / 1000);
    localparam int          OVW_CNT_W        = 22;

    // Debounce sequencer states
    typedef enum logic [1:0] {
        OVW_IDLE    = 2'b00,
        OVW_COUNT   = 2'b01,
        OVW_TRIPPED = 2'b10
    } ovw_state_t;
endpackage : ovw_pkg

/* File: verilog/ovw_debounce.sv */
`timescale 1ns/10ps
module ovw_debounce #(
    parameter int unsigned DEBOUNCE_CYC = ovw_pkg::OVW_DEBOUNCE_CYC
) (
    input  wire logic core_clk,
    input  wire logic rst,
    input  wire logic trip,
    output logic      done_q
);
    import ovw_pkg::*;

    localparam logic [OVW_CNT_W-1:0] LIMIT_M1 = OVW_CNT_W'(DEBOUNCE_CYC - 1);
    localparam logic [OVW_CNT_W-1:0] CNT_ONE  = 22'h000001;

    ovw_state_t           state_q;
    ovw_state_t           state_d;
    logic [OVW_CNT_W-1:0] cnt_q;
    logic [OVW_CNT_W-1:0] cnt_d;
    logic                 done_d;

    // Count consecutive trip cycles; any gap starts the count over
    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        done_d  = done_q;
        unique case (state_q)
            OVW_IDLE: begin
                if (trip) begin
                    cnt_d   = CNT_ONE;
                    state_d = OVW_COUNT;
                end
            end
            OVW_COUNT: begin
                if (!trip) begin
                    cnt_d   = '0;
                    state_d = OVW_IDLE;
                end else if (cnt_q == LIMIT_M1) begin
                    cnt_d   = '0;
                    done_d  = 1'b1;
                    state_d = OVW_TRIPPED;
                end else begin
                    cnt_d   = cnt_q + CNT_ONE;
                end
            end
            OVW_TRIPPED: begin
                if (!trip) begin
                    done_d  = 1'b0;
                    state_d = OVW_IDLE;
                end
            end
            default: begin
                cnt_d   = '0;
                done_d  = 1'b0;
                state_d = OVW_IDLE;
            end
        endcase
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (rst) begin
            state_q <= OVW_IDLE;
            cnt_q   <= '0;
            done_q  <= 1'b0;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            done_q  <= done_d;
        end
    end
endmodule : ovw_debounce

/* File: verilog/ovw_compare.sv */
`timescale 1ns/10ps
// How it works
// - The warning flag sets only after the trip condition has held unbroken for 100 ms.
// - The 9-bit threshold is the 8 programmed bits with a zero placed above them.
// - Only the nine top bits of the sensor ADC result are compared; lower bits are ignored.
// - A reading strictly below the 9-bit threshold is the trip condition.
// - Each threshold code is 3.125 mV, 256 codes spanning 0 mV to 796.875 mV.
// - All eight threshold bits are readable and writable; a read returns the stored value, not a write in the same cycle.
module ovw_compare #(
    parameter int unsigned DEBOUNCE_CYC = ovw_pkg::OVW_DEBOUNCE_CYC
) (
    input  wire logic                            core_clk,
    input  wire logic                            rst,
    input  wire logic [ovw_pkg::OVW_ADDR_W-1:0]  reg_addr,
    input  wire logic                            reg_wr_en,
    input  wire logic [ovw_pkg::OVW_THRESH_W-1:0] reg_wr_data,
    input  wire logic                            reg_rd_en,
    output logic      [ovw_pkg::OVW_THRESH_W-1:0] reg_rd_data_q,
    output logic                                 reg_rd_valid_q,
    input  wire logic [ovw_pkg::OVW_ADC_W-1:0]   adc_result,
    input  wire logic                            adc_valid,
    output logic                                 overtemp_warning_q,
    output logic      [ovw_pkg::OVW_UV_W-1:0]    threshold_uv_q
);
    import ovw_pkg::*;

    logic [OVW_THRESH_W-1:0] thresh_q;
    logic [OVW_THRESH_W-1:0] thresh_d;
    logic [OVW_THRESH_W-1:0] rd_data_d;
    logic                    rd_valid_d;
    logic [OVW_CMP_W-1:0]    reading_q;
    logic [OVW_CMP_W-1:0]    reading_d;
    logic [OVW_CMP_W-1:0]    thresh_ext;
    logic                    trip_q;
    logic                    trip_d;
    logic                    warn_d;
    logic [OVW_UV_W-1:0]     uv_d;
    logic                    deb_done;
    logic                    addr_hit;

    // Register port decode, write and read answer
    always_comb begin
        addr_hit   = (reg_addr == OVW_THRESH_ADDR);
        thresh_d   = thresh_q;
        rd_data_d  = reg_rd_data_q;
        rd_valid_d = 1'b0;
        if (reg_wr_en && addr_hit) begin
            thresh_d = reg_wr_data;
        end
        if (reg_rd_en) begin
            rd_valid_d = 1'b1;
            rd_data_d  = addr_hit ? thresh_q : OVW_UNMAPPED_RD;
        end
    end

    // Register state
    always_ff @(posedge core_clk) begin
        if (rst) begin
            thresh_q       <= OVW_THRESH_RST;
            reg_rd_data_q  <= '0;
            reg_rd_valid_q <= 1'b0;
        end else begin
            thresh_q       <= thresh_d;
            reg_rd_data_q  <= rd_data_d;
            reg_rd_valid_q <= rd_valid_d;
        end
    end

    // Sample capture, threshold extension, compare and scaling
    always_comb begin
        reading_d  = adc_valid ? adc_result[OVW_ADC_W-1 -: OVW_CMP_W] : reading_q;
        thresh_ext = {1'b0, thresh_q};
        trip_d     = (reading_q < thresh_ext);
        uv_d       = OVW_UV_W'({12'h000, thresh_q} * OVW_STEP_UV);
        warn_d     = deb_done;
    end

    // Datapath registers; reset loads an all-ones reading so nothing trips before the first sample
    always_ff @(posedge core_clk) begin
        if (rst) begin
            reading_q          <= '1;
            trip_q             <= 1'b0;
            threshold_uv_q     <= '0;
            overtemp_warning_q <= 1'b0;
        end else begin
            reading_q          <= reading_d;
            trip_q             <= trip_d;
            threshold_uv_q     <= uv_d;
            overtemp_warning_q <= warn_d;
        end
    end

    // Consecutive-trip debounce
    ovw_debounce #(
        .DEBOUNCE_CYC (DEBOUNCE_CYC)
    ) u_debounce (
        .core_clk (core_clk),
        .rst      (rst),
        .trip     (trip_q),
        .done_q   (deb_done)
    );

    // Checking helpers: run length of the trip condition, saturating
    localparam logic [OVW_CNT_W:0] RUN_FULL = (OVW_CNT_W+1)'(DEBOUNCE_CYC);
    localparam logic [OVW_CNT_W:0] RUN_ONE  = 23'h000001;
    logic [OVW_CNT_W:0] trip_run_q;
    logic [OVW_CNT_W:0] trip_run_d;

    // Next run length
    always_comb begin
        if (!trip_q) begin
            trip_run_d = '0;
        end else if (trip_run_q == RUN_FULL) begin
            trip_run_d = trip_run_q;
        end else begin
            trip_run_d = trip_run_q + RUN_ONE;
        end
    end

    // Run length register
    always_ff @(posedge core_clk) begin
        if (rst) begin
            trip_run_q <= '0;
        end else begin
            trip_run_q <= trip_run_d;
        end
    end

    // All checks run on the core clock and rest during reset
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);

    // Named steps of register access and of a trip run
    sequence s_write_hit;
        reg_wr_en && (reg_addr == OVW_THRESH_ADDR);
    endsequence

    sequence s_read_hit;
        reg_rd_en && !reg_wr_en && (reg_addr == OVW_THRESH_ADDR);
    endsequence

    sequence s_trip_start;
        !trip_q ##1 trip_q;
    endsequence

    sequence s_trip_held;
        trip_q ##1 trip_q;
    endsequence

    // Written value is stored and then read back
    chk_thresh_write: assert property (
        s_write_hit |=> thresh_q == $past(reg_wr_data))
        else $error("threshold write not stored");
    chk_read_back: assert property (
        s_read_hit |=> reg_rd_valid_q && reg_rd_data_q == $past(thresh_q))
        else $error("threshold read returned wrong value");
    // Read marker pulses once per read, threshold moves only on a write
    chk_rd_pulse: assert property (
        reg_rd_en |=> reg_rd_valid_q)
        else $error("read answer marker missing");
    chk_rd_quiet: assert property (
        !reg_rd_en |=> !reg_rd_valid_q)
        else $error("read answer marker without a read");
    chk_thresh_keep: assert property (
        !(reg_wr_en && reg_addr == OVW_THRESH_ADDR) |=> $stable(thresh_q))
        else $error("threshold changed without a write");

    // Only the top nine ADC bits are captured
    chk_top_bits: assert property (
        adc_valid |=> reading_q == $past(adc_result[11:3]))
        else $error("reading not taken from top nine bits");

    // Zero-extended threshold can never exceed a reading with bit 8 set
    chk_zero_msb: assert property (
        reading_q[8] |=> !trip_q)
        else $error("trip with reading above 9-bit threshold range");

    // Equal reading does not trip, one code below does
    chk_strict_less: assert property (
        (reading_q == {1'b0, thresh_q}) |=> !trip_q)
        else $error("equal reading tripped");
    chk_one_below: assert property (
        (thresh_q != 8'h00 && reading_q + 9'h001 == {1'b0, thresh_q}) |=> trip_q)
        else $error("reading below threshold did not trip");

    // Scaled threshold follows the programmed code, after a write and at all times
    chk_uv_scale: assert property (
        s_write_hit ##1 !reg_wr_en
        |=> threshold_uv_q == 20'({12'h000, $past(thresh_q)} * 20'h00C35))
        else $error("threshold scaling wrong");
    chk_uv_track: assert property (
        threshold_uv_q == 20'({12'h000, $past(thresh_q)} * 20'h00C35))
        else $error("scaled threshold out of step with the code");

    // Flag rises exactly when the trip has held for the full debounce
    chk_flag_hold: assert property (
        $rose(overtemp_warning_q) |-> $past(trip_run_q) == RUN_FULL)
        else $error("warning flag rose before debounce completed");
    chk_flag_in_time: assert property (
        (trip_run_q == RUN_FULL && $past(trip_run_q) != RUN_FULL) |=> overtemp_warning_q)
        else $error("warning flag late after debounce");
    chk_flag_stays: assert property (
        s_trip_held ##0 overtemp_warning_q |=> overtemp_warning_q)
        else $error("warning flag dropped while trip held");

    // A fresh trip run never shows the flag in the two cycles after its first
    chk_no_early_flag: assert property (
        s_trip_start |=> !overtemp_warning_q [*2])
        else $error("warning flag shown at the start of a new trip run");

    // Flag needs the trip condition two edges earlier
    chk_flag_needs_trip: assert property (
        overtemp_warning_q |-> $past(trip_q, 2))
        else $error("warning flag without a trip condition");

    // A break in the trip condition drops the flag and restarts the count
    chk_restart: assert property (
        !trip_q |-> ##2 !overtemp_warning_q)
        else $error("flag held after trip condition cleared");
endmodule : ovw_compare

/* File: tb/testbench.sv */
`timescale 1ns/10ps
module testbench;
    import ovw_pkg::*;
    localparam int N = 8;
    logic        core_clk;
    logic        rst;
    logic [15:0] reg_addr;
    logic        reg_wr_en;
    logic [7:0]  reg_wr_data;
    logic        reg_rd_en;
    logic [7:0]  reg_rd_data_q;
    logic        reg_rd_valid_q;
    logic [11:0] adc_result;
    logic        adc_valid;
    logic        overtemp_warning_q;
    logic [19:0] threshold_uv_q;
    int          bad_count;
    int          n_tests;

    ovw_compare #(.DEBOUNCE_CYC(N)) u_dut (
        .core_clk(core_clk), .rst(rst), .reg_addr(reg_addr), .reg_wr_en(reg_wr_en),
        .reg_wr_data(reg_wr_data), .reg_rd_en(reg_rd_en), .reg_rd_data_q(reg_rd_data_q),
        .reg_rd_valid_q(reg_rd_valid_q), .adc_result(adc_result), .adc_valid(adc_valid),
        .overtemp_warning_q(overtemp_warning_q), .threshold_uv_q(threshold_uv_q));

    // 25 MHz core clock
    always #20 core_clk = ~core_clk;

    task check(input string name, input logic [31:0] exp, input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            $display("unexpected %s: expected %h, seen %h", name, exp, got);
            bad_count++;
        end
    endtask : check

    // One register write, strobe held for exactly one edge
    task wr(input logic [15:0] addr, input logic [7:0] data);
        @(posedge core_clk);
        reg_addr <= addr; reg_wr_data <= data; reg_wr_en <= 1'b1;
        @(posedge core_clk);
        reg_wr_en <= 1'b0;
    endtask : wr

    // One register read; answer is judged just after the taking edge, while valid stands
    task rd(input logic [15:0] addr, input logic [7:0] exp);
        @(posedge core_clk);
        reg_addr <= addr; reg_rd_en <= 1'b1;
        @(posedge core_clk);
        reg_rd_en <= 1'b0;
        #1;
        check("rd_valid", 32'h1, {31'h0, reg_rd_valid_q});
        check("rd_data", {24'h0, exp}, {24'h0, reg_rd_data_q});
    endtask : rd

    // Write threshold and check the scaled microvolt status two edges later
    task wr_thr(input logic [7:0] code);
        wr(OVW_THRESH_ADDR, code);
        repeat (2) @(posedge core_clk);
        #1;
        check("threshold_uv", 32'(OVW_STEP_UV) * {24'h0, code}, {12'h0, threshold_uv_q});
    endtask : wr_thr

    // Present one ADC sample; returns at its capturing edge
    task capture(input logic [11:0] val);
        @(posedge core_clk);
        adc_result <= val; adc_valid <= 1'b1;
        @(posedge core_clk);
        adc_valid <= 1'b0;
    endtask : capture

    // Flag must be low at edge n-1 after capture and be high at edge n
    task flag_at(input int n);
        repeat (n - 1) @(posedge core_clk);
        #1;
        check("flag_early", 32'h0, {31'h0, overtemp_warning_q});
        @(posedge core_clk);
        #1;
        check("flag_set", 32'h1, {31'h0, overtemp_warning_q});
    endtask : flag_at

    task flag_low(input int n);
        repeat (n) @(posedge core_clk);
        #1;
        check("flag_low", 32'h0, {31'h0, overtemp_warning_q});
    endtask : flag_low

    task t_reset;
        check("uv_reset", 32'h0, {12'h0, threshold_uv_q});
        flag_low(1);
        rd(OVW_THRESH_ADDR, 8'h00);
    endtask : t_reset

    task t_regs;
        wr_thr(8'hFA);
        rd(OVW_THRESH_ADDR, 8'hFA);
        wr(16'hFE1B, 8'h55);
        rd(OVW_THRESH_ADDR, 8'hFA);
        rd(16'hFE1B, OVW_UNMAPPED_RD);
        wr_thr(8'h03);
        rd(OVW_THRESH_ADDR, 8'h03);
    endtask : t_regs

    task t_trip;
        wr_thr(8'h80);
        capture({9'h07F, 3'h7});
        flag_at(N + 2);
        capture({9'h080, 3'h0});
        flag_low(3);
        flag_low(N + 3);
    endtask : t_trip

    task t_msb;
        capture({9'h100, 3'h0});
        flag_low(N + 4);
        capture({9'h07F, 3'h0});
        flag_at(N + 2);
        capture(12'hFFF);
        flag_low(3);
    endtask : t_msb

    // A one-cycle reading at the threshold part way through must restart the full count
    task t_restart;
        capture({9'h050, 3'h0});
        repeat (N - 3) @(posedge core_clk);
        adc_result <= {9'h080, 3'h0}; adc_valid <= 1'b1;
        @(posedge core_clk);
        adc_result <= {9'h050, 3'h0};
        @(posedge core_clk);
        adc_valid <= 1'b0;
        flag_at(N + 2);
        capture(12'hFFF);
        flag_low(3);
    endtask : t_restart

    task stop_test;
        if (bad_count == 0 && n_tests > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : stop_test

    // Watchdog well beyond the 125 or so cycles the tests need
    initial begin
        #200000;
        bad_count++;
        stop_test;
    end

    // Main sequence
    initial begin
        core_clk = 1'b0; rst = 1'b1; reg_addr = 16'h0000; reg_wr_en = 1'b0;
        reg_wr_data = 8'h00; reg_rd_en = 1'b0; adc_result = 12'hFFF; adc_valid = 1'b0;
        bad_count = 0; n_tests = 0;
        repeat (16) @(posedge core_clk);
        rst <= 1'b0;
        t_reset;
        t_regs;
        t_trip;
        t_msb;
        t_restart;
        stop_test;
    end
endmodule : testbench
